// ---- logic/timer_section_pkg.sv ----
/*
  Constants for the timer section: register offsets, field positions,
  reset values, mode codes and tick timing.
  Assumes a single 200 MHz system clock and an 8-bit register port.
*/
package timer_section_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RUN_CONTROL = 8'h0e;
  localparam logic [7:0] ADDR_ZERO_CONFIG = 8'h0f;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h10;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h11;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h12;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'h13;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h41;

  // ----------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------
  localparam int          CFG_STOP_RX_BIT  = 7;
  localparam int          CFG_START_LSB    = 4;
  localparam int          CFG_RELOAD_BIT   = 3;
  localparam int          CFG_TICK_LSB     = 0;
  localparam logic [7:0]  CFG_WRITE_MASK   = 8'hbb;
  localparam int          IRQ_UNDERFLOW    = 0;
  localparam int          IRQ_RX_STOP      = 1;
  localparam int          IRQ_WIDTH        = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CONFIG_RESET     = 8'h00;
  localparam logic [15:0] RELOAD_RESET     = 16'h0000;
  localparam logic [3:0]  RUN_RESET        = 4'h0;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] START_NONE      = 2'h0;
  localparam logic [1:0] START_TX_END    = 2'h1;
  localparam logic [1:0] START_TRIM_HOLD = 2'h2;
  localparam logic [1:0] START_TRIM_UNDR = 2'h3;
  localparam logic [1:0] TICK_FAST       = 2'h0;
  localparam logic [1:0] TICK_SLOW       = 2'h1;
  localparam logic [1:0] TICK_TIMER_TWO  = 2'h2;
  localparam logic [1:0] TICK_TIMER_ONE  = 2'h3;

  // ----------------------------------------------------------------
  // Tick timing
  // ----------------------------------------------------------------
  localparam longint SYS_CLK_HZ   = 64'd200_000_000;
  localparam longint FAST_TICK_HZ = 64'd13_560_000;
  localparam int     ACC_WIDTH    = 24;
  localparam logic [ACC_WIDTH-1:0] ACC_STEP =
    ACC_WIDTH'((FAST_TICK_HZ << ACC_WIDTH) / SYS_CLK_HZ);
  localparam int     SLOW_DIVIDE  = 64;

endpackage

// ---- logic/tick_bus_if.sv ----
/*
  Tick strobes from the tick generator to the timer core.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/100ps
interface tick_bus_if;
  logic fast_tick;
  logic slow_tick;
  modport src (output fast_tick, output slow_tick);
  modport dst (input fast_tick, input slow_tick);
endinterface // tick_bus_if

// ---- logic/tick_generator.sv ----
/*
  Makes the 13.56 MHz and 211.875 kHz counting strobes from sys_clk.
  Assumes sys_clk at the rate set in the package; jitter of one
  period is accepted in exchange for needing no second clock.
*/
`timescale 1ns/100ps
module tick_generator (
  input wire logic    sys_clk,
  input wire logic    rst_n,
  tick_bus_if.src     ticks
);
  localparam int DIV_W = $clog2(timer_section_pkg::SLOW_DIVIDE);

  logic [timer_section_pkg::ACC_WIDTH:0]   acc_d;
  logic [timer_section_pkg::ACC_WIDTH-1:0] acc_q;
  logic [DIV_W-1:0]                        div_q;
  logic                                    fast_q;
  logic                                    slow_q;

  assign acc_d = {1'b0, acc_q} + {1'b0, timer_section_pkg::ACC_STEP};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q  <= '0;
      div_q  <= '0;
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      acc_q  <= acc_d[timer_section_pkg::ACC_WIDTH-1:0];
      fast_q <= acc_d[timer_section_pkg::ACC_WIDTH];
      slow_q <= acc_d[timer_section_pkg::ACC_WIDTH] && (div_q == '1);
      if (acc_d[timer_section_pkg::ACC_WIDTH]) begin
        div_q <= div_q + 1'b1;
      end
    end
  end

  assign ticks.fast_tick = fast_q;
  assign ticks.slow_tick = slow_q;
endmodule // tick_generator

// ---- logic/timer_section.sv ----
/*
  Timer section run control plus the complete first timer: register
  port, start and stop sources, tick selection, down counter, reload,
  underflow interrupt.
  Assumes tx_end, rx_first_bits and the underflow pulses of timers one
  and two come from logic on sys_clk; trim_edge_pin is asynchronous.
*/
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module timer_section (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_end,
  input  wire logic       rx_first_bits,
  input  wire logic       trim_edge_pin,
  input  wire logic       timer_one_underflow,
  input  wire logic       timer_two_underflow,
  input  wire logic [2:0] other_timer_done,
  output logic            timer_three_active,
  output logic            timer_two_active,
  output logic            timer_one_active,
  output logic            timer_zero_active,
  output logic            timer_zero_underflow,
  output logic            irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_trim(input logic [1:0] sel);
    return sel == timer_section_pkg::START_TRIM_HOLD ||
           sel == timer_section_pkg::START_TRIM_UNDR;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------
  // Tick source
  // ----------------------------------------------------------------
  tick_bus_if ticks ();

  tick_generator u_ticks (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .ticks   (ticks)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0]                          run_q;
  logic [3:0]                          run_d;
  logic [7:0]                          config_q;
  logic [15:0]                         reload_q;
  logic [15:0]                         count_q;
  logic [15:0]                         count_d;
  logic [timer_section_pkg::IRQ_WIDTH-1:0] irq_status_q;
  logic [timer_section_pkg::IRQ_WIDTH-1:0] irq_mask_q;
  logic [7:0]                          rdata_q;
  logic                                underflow_q;
  logic                                trim_meta_q;
  logic                                trim_sync_q;
  logic                                trim_last_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire       wr_run    = reg_wr && hit(reg_addr,
                           timer_section_pkg::ADDR_RUN_CONTROL);
  wire       wr_config = reg_wr && hit(reg_addr,
                           timer_section_pkg::ADDR_ZERO_CONFIG);
  wire       wr_hi     = reg_wr && hit(reg_addr,
                           timer_section_pkg::ADDR_RELOAD_HIGH);
  wire       wr_lo     = reg_wr && hit(reg_addr,
                           timer_section_pkg::ADDR_RELOAD_LOW);
  wire       wr_status = reg_wr && hit(reg_addr,
                           timer_section_pkg::ADDR_IRQ_STATUS);
  wire       wr_mask   = reg_wr && hit(reg_addr,
                           timer_section_pkg::ADDR_IRQ_MASK);

  wire [1:0] start_sel = config_q[timer_section_pkg::CFG_START_LSB +: 2];
  wire [1:0] tick_sel  = config_q[timer_section_pkg::CFG_TICK_LSB +: 2];
  wire       stop_rx   = config_q[timer_section_pkg::CFG_STOP_RX_BIT];
  wire       auto_rld  = config_q[timer_section_pkg::CFG_RELOAD_BIT];
  wire       trimming  = is_trim(start_sel);
  wire       running   = run_q[0];

  // Only the second synchroniser stage and its delayed copy are looked at
  wire       trim_rise = trim_sync_q && !trim_last_q;

  // Masked software control: bit n of the low nibble enables bit n+4
  wire       sw_touch  = wr_run && reg_wdata[0];
  wire       sw_value  = reg_wdata[4];

  // Hardware start and stop sources for the first timer
  wire       hw_start  = !running && (
                         (start_sel == timer_section_pkg::START_TX_END
                          && tx_end) ||
                         (trimming && trim_rise));
  wire       hw_rx_stop = running && stop_rx && !trimming
                          && rx_first_bits;
  wire       trim_stop = running && trimming && trim_rise;

  // Counting tick selection
  logic      tick;
  always_comb begin
    unique case (tick_sel)
      timer_section_pkg::TICK_FAST:      tick = ticks.fast_tick;
      timer_section_pkg::TICK_SLOW:      tick = ticks.slow_tick;
      timer_section_pkg::TICK_TIMER_TWO: tick = timer_two_underflow;
      timer_section_pkg::TICK_TIMER_ONE: tick = timer_one_underflow;
    endcase
  end

  // Trimming without underflow holds at zero instead of wrapping
  wire       hold_zero = start_sel == timer_section_pkg::START_TRIM_HOLD;
  wire       at_zero   = count_q == 16'h0000;
  wire       underflow = running && tick && at_zero && !hold_zero;
  wire       wrap_stop = underflow && !auto_rld;

  wire       sw_start  = sw_touch && sw_value;
  wire       sw_stop   = sw_touch && !sw_value;
  wire       start_evt = sw_start || (!sw_touch && hw_start);
  wire       stop_evt  = sw_stop || (!sw_touch &&
                         (hw_rx_stop || trim_stop || wrap_stop));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    run_d = run_q;
    for (int i = 1; i < 4; i++) begin
      if (other_timer_done[i-1]) begin
        run_d[i] = 1'b0;
      end
      if (wr_run && reg_wdata[i]) begin
        run_d[i] = reg_wdata[i+4];
      end
    end
    if (start_evt) begin
      run_d[0] = 1'b1;
    end else if (stop_evt) begin
      run_d[0] = 1'b0;
    end
  end

  always_comb begin
    count_d = count_q;
    if (start_evt) begin
      count_d = reload_q;
    end else if (underflow && auto_rld) begin
      count_d = reload_q;
    end else if (running && tick && !at_zero && !stop_evt) begin
      count_d = count_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_meta_q <= 1'b0;
      trim_sync_q <= 1'b0;
      trim_last_q <= 1'b0;
    end else begin
      trim_meta_q <= trim_edge_pin;
      trim_sync_q <= trim_meta_q;
      trim_last_q <= trim_sync_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q       <= timer_section_pkg::RUN_RESET;
      count_q     <= timer_section_pkg::RELOAD_RESET;
      underflow_q <= 1'b0;
    end else begin
      run_q       <= run_d;
      count_q     <= count_d;
      underflow_q <= underflow;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= timer_section_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      config_q <= reg_wdata & timer_section_pkg::CFG_WRITE_MASK;
    end
  end

  // Reload bytes only feed the counter at a start or reload
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_q <= timer_section_pkg::RELOAD_RESET;
    end else begin
      if (wr_hi) begin
        reload_q[15:8] <= reg_wdata;
      end
      if (wr_lo) begin
        reload_q[7:0] <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // A new event wins over a write-one clear in the same cycle
  wire [timer_section_pkg::IRQ_WIDTH-1:0] irq_set = {hw_rx_stop && !sw_touch,
                                                     underflow};
  wire [timer_section_pkg::IRQ_WIDTH-1:0] irq_clr =
    wr_status ? reg_wdata[timer_section_pkg::IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_q <= '0;
      irq_mask_q   <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      if (wr_mask) begin
        irq_mask_q <= reg_wdata[timer_section_pkg::IRQ_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      timer_section_pkg::ADDR_RUN_CONTROL: rd_mux = {run_q, 4'h0};
      timer_section_pkg::ADDR_ZERO_CONFIG: rd_mux = config_q;
      timer_section_pkg::ADDR_RELOAD_HIGH: rd_mux = reload_q[15:8];
      timer_section_pkg::ADDR_RELOAD_LOW:  rd_mux = reload_q[7:0];
      timer_section_pkg::ADDR_COUNT_HIGH:  rd_mux = count_q[15:8];
      timer_section_pkg::ADDR_COUNT_LOW:   rd_mux = count_q[7:0];
      timer_section_pkg::ADDR_IRQ_STATUS:
        rd_mux = {6'h00, irq_status_q};
      timer_section_pkg::ADDR_IRQ_MASK:
        rd_mux = {6'h00, irq_mask_q};
      default:                             rd_mux = 8'h00;
    endcase
  end

  // Count bytes are not coherent across two reads while ticking fast
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata            = rdata_q;
  assign timer_three_active   = run_q[3];
  assign timer_two_active     = run_q[2];
  assign timer_one_active     = run_q[1];
  assign timer_zero_active    = run_q[0];
  assign timer_zero_underflow = underflow_q;
  assign irq                  = |(irq_status_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_mask_gates_run: assert property (
    wr_run && !reg_wdata[1] && !other_timer_done[0] |=> $stable(run_q[1]))
    else $error("Unmasked running bit changed");

  chk_all_ones_start: assert property (
    reg_wr && reg_addr == timer_section_pkg::ADDR_RUN_CONTROL
    && reg_wdata == 8'hff |=> run_q == 4'hf)
    else $error("Writing all ones did not start every timer");

  chk_start_loads: assert property (
    start_evt |=> count_q == $past(reload_q) && timer_zero_active)
    else $error("Start did not load the reload value");

  chk_rx_stop: assert property (
    running && stop_rx && !trimming && rx_first_bits && !sw_touch
    |=> !timer_zero_active)
    else $error("Stop on receive did not stop the timer");

  chk_trim_ignores_rx: assert property (
    running && trimming && rx_first_bits && !trim_rise && !wr_run
    && !underflow |=> timer_zero_active)
    else $error("Trimming mode stopped on receive");

  chk_tx_start: assert property (
    !running && start_sel == timer_section_pkg::START_TX_END && tx_end
    && !wr_run |=> timer_zero_active)
    else $error("End of transmission did not start the timer");

  chk_no_self_start: assert property (
    !running && start_sel == timer_section_pkg::START_NONE && !wr_run
    |=> !timer_zero_active)
    else $error("Timer started without a start source");

  chk_reload_wrap: assert property (
    underflow && auto_rld && !wr_run
    |=> timer_zero_active && count_q == $past(reload_q))
    else $error("Auto reload did not restart the count");

  chk_oneshot_stop: assert property (
    underflow && !auto_rld && !wr_run |=> !timer_zero_active)
    else $error("One-shot timer kept running after underflow");

  chk_underflow_flag: assert property (
    underflow |=> irq_status_q[timer_section_pkg::IRQ_UNDERFLOW]
    ##0 timer_zero_underflow)
    else $error("Underflow flag not set");

  chk_decrement: assert property (
    running && tick && !at_zero && !start_evt && !stop_evt
    |=> count_q == $past(count_q) - 16'h0001)
    else $error("Count did not decrement on tick");

  chk_idle_holds: assert property (
    !running && !start_evt |=> $stable(count_q))
    else $error("Stopped count changed");

  chk_reload_write_quiet: assert property (
    (wr_hi || wr_lo) && !start_evt && !underflow && !tick
    |=> $stable(count_q))
    else $error("Reload write disturbed the count");

  chk_reserved_zero: assert property (
    wr_config |=> config_q[6] == 1'b0 && config_q[2] == 1'b0)
    else $error("Reserved configuration bit stored");

  chk_count_read: assert property (
    reg_rd && reg_addr == timer_section_pkg::ADDR_COUNT_HIGH
    |=> reg_rdata == $past(count_q[15:8]))
    else $error("Count high byte read wrong");

  cov_tx_start_underflow: cover property (
    tx_end && !running ##[1:1000] underflow);
  cov_cascade_tick: cover property (
    tick_sel == timer_section_pkg::TICK_TIMER_ONE && running && tick);
  cov_trim_cycle: cover property (
    trimming && trim_rise && !running ##[1:1000] trim_stop);

endmodule // timer_section

// ---- bench/tb_timer_section.sv ----
/* Self-checking bench for timer_section with a counting model.
   Assumes the design files are compiled first; one 200 MHz clock. */
`timescale 1ns/100ps
module tb_timer_section;
  logic        sys_clk;
  logic        rst_n;
  logic  [7:0] reg_addr;
  logic  [7:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic  [7:0] reg_rdata;
  logic  [4:0] ev;
  logic  [2:0] tdone;
  logic  [3:0] act;
  logic        uf;
  logic        irq;
  int          n_fail;
  int          check_count;
  int          seed;
  int          exp_cnt;
  logic [15:0] v;
  logic  [7:0] b;
  logic  [7:0] hi;
  logic        ok;
  logic  [7:0] addrs [8] = '{8'h0e, 8'h0f, 8'h10, 8'h11,
                             8'h12, 8'h13, 8'h40, 8'h41};

  timer_section timer_section_inst (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .tx_end              (ev[0]),
    .rx_first_bits       (ev[1]),
    .trim_edge_pin       (ev[2]),
    .timer_one_underflow (ev[3]),
    .timer_two_underflow (ev[4]),
    .other_timer_done    (tdone),
    .timer_three_active  (act[3]),
    .timer_two_active    (act[2]),
    .timer_one_active    (act[1]),
    .timer_zero_active   (act[0]),
    .timer_zero_underflow(uf),
    .irq                 (irq)
  );

  // ----------------------------------------------------------------
  // Bus and event tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Count bytes are not latched together; only read while it is still
  task automatic rdcnt(output logic [15:0] c);
    rd(8'h12, c[15:8]);
    rd(8'h13, c[7:0]);
  endtask

  task automatic pulse(input int i, input int len);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    repeat (len) @(posedge sys_clk);
    ev[i] <= 1'b0;
    #1;
  endtask

  task automatic wait_uf(input int lim, input bit must, output logic f);
    f = 1'b0;
    for (int i = 0; i < lim && !f; i++) begin
      @(posedge sys_clk);
      #1;
      f = (uf === 1'b1);
    end
    if (must && !f) begin
      n_fail++;
      give_verdict;
    end
  endtask

  // Stop first so the count neither ticks nor underflows while config and reload are written
  task automatic start(input logic [15:0] rl, input logic [7:0] cfg);
    wr(8'h0e, 8'h01);
    wr(8'h0f, cfg);
    wr(8'h10, rl[15:8]);
    wr(8'h11, rl[7:0]);
    wr(8'h0e, 8'h11);
    exp_cnt = rl;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {n_fail, check_count} = '0;
    seed = 32'hb7ef;
    {rst_n, reg_wr, reg_rd, ev, tdone} = '0;
    {reg_addr, reg_wdata} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (addrs[i]) begin
      rd(addrs[i], b);
      chk(b, 8'h00);
    end
    wr(8'h0e, 8'hf0);
    chk(act, 4'h0);
    wr(8'h0e, 8'hff);
    rd(8'h0e, b);
    chk(b, 8'hf0);
    wr(8'h0e, 8'h0e);
    chk(act, 4'h1);
    wr(8'h0e, 8'h22);
    @(posedge sys_clk);
    tdone <= 3'h1;
    @(posedge sys_clk);
    tdone <= 3'h0;
    #1;
    chk(act, 4'h1);
    wr(8'h0f, 8'hff);
    rd(8'h0f, b);
    chk(b, 8'hbb);
    hi = 8'($random(seed)) | 8'h01;
    start({hi, 8'($random(seed))}, 8'h02);
    rdcnt(v);
    chk(v, 16'(exp_cnt));
    wr(8'h10, ~hi);
    wr(8'h11, 8'h00);
    rdcnt(v);
    chk(v, 16'(exp_cnt));
    repeat (3) pulse(4, 1);
    pulse(3, 1);
    exp_cnt -= 3;
    rdcnt(v);
    chk(v, 16'(exp_cnt));
    wr(8'h0f, 8'h03);
    repeat (2) pulse(3, 1);
    exp_cnt -= 2;
    rdcnt(v);
    chk(v, 16'(exp_cnt));
    start(16'h0001, 8'h0b);
    repeat (2) pulse(3, 1);
    rdcnt(v);
    chk({act[0], v}, 17'h1_0001);
    start(16'h0003, 8'h00);
    wait_uf(400, 1'b1, ok);
    rdcnt(v);
    chk({act[0], v}, 17'h0_0000);
    rd(8'h40, b);
    chk(b, 8'h01);
    chk(irq, 1'b0);
    wr(8'h41, 8'h01);
    chk(irq, 1'b1);
    wr(8'h40, 8'h01);
    chk(irq, 1'b0);
    start(16'h0001, 8'h01);
    wait_uf(800, 1'b0, ok);
    chk(ok, 1'b0);
    wait_uf(2500, 1'b1, ok);
    for (int m = 0; m < 4; m++) begin
      wr(8'h0e, 8'h01);
      wr(8'h0f, 8'(m << 4) | 8'h02);
      pulse(0, 1);
      pulse(2, 2);
      repeat (5) @(posedge sys_clk);
      #1;
      chk(act[0], 1'(m != 0));
    end
    wr(8'h0f, 8'hb2);
    pulse(1, 1);
    chk(act[0], 1'b1);
    pulse(2, 2);
    repeat (5) @(posedge sys_clk);
    #1;
    chk(act[0], 1'b0);
    start(16'h0040, 8'h02);
    pulse(1, 1);
    chk(act[0], 1'b1);
    wr(8'h0f, 8'h82);
    pulse(1, 1);
    chk(act[0], 1'b0);
    rd(8'h40, b);
    chk(b, 8'h03);
    wr(8'h40, 8'h03);
    // Trimming without underflow parks at zero and keeps running
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h01);
    wr(8'h0f, 8'h23);
    pulse(2, 2);
    repeat (4) @(posedge sys_clk);
    repeat (3) pulse(3, 1);
    rdcnt(v);
    chk({act[0], v}, 17'h1_0000);
    rd(8'h40, b);
    chk(b, 8'h00);
    wr(8'h0f, 8'h3b);
    pulse(3, 1);
    rdcnt(v);
    chk({act[0], v}, 17'h1_0001);
    rd(8'h40, b);
    chk(b, 8'h01);
    give_verdict;
  end
endmodule // tb_timer_section
